// *** pkg/atn_params.svh ***
`ifndef ATN_PARAMS_SVH
`define ATN_PARAMS_SVH

// ****************************************
// Word format
// ****************************************
`define ATN_WORD_W        5
`define ATN_BIT_8DB       4
`define ATN_BIT_4DB       3
`define ATN_BIT_2DB       2
`define ATN_BIT_1DB       1
`define ATN_BIT_HALF_DB   0

// ****************************************
// Timing, ns and derived sys_clk cycles
// ****************************************
`define ATN_CLK_NS        8
`define ATN_SCLK_MAX_MHZ  10
`define ATN_SCLK_PHASE_NS 30
`define ATN_STB_SETUP_NS  10
`define ATN_STB_WIDTH_NS  30
`define ATN_BIT_HOLD_NS   10
`define ATN_SETTLE_NS     700
// Half period from the frequency limit (50 ns) dominates the 30 ns phase
`define ATN_HALF_MIN_CYC  ((500 / `ATN_SCLK_MAX_MHZ + `ATN_CLK_NS - 1) / `ATN_CLK_NS)
`define ATN_STB_SETUP_CYC ((`ATN_STB_SETUP_NS + `ATN_CLK_NS - 1) / `ATN_CLK_NS)
`define ATN_STB_WIDTH_CYC ((`ATN_STB_WIDTH_NS + `ATN_CLK_NS - 1) / `ATN_CLK_NS)
`define ATN_BIT_HOLD_CYC  ((`ATN_BIT_HOLD_NS + `ATN_CLK_NS - 1) / `ATN_CLK_NS)
// Longest time rounds down
`define ATN_SETTLE_CYC    (`ATN_SETTLE_NS / `ATN_CLK_NS)
`define ATN_BOOT_CYC      3

// ****************************************
// Controller register map (AXI4-Lite)
// ****************************************
`define ATN_REG_WORD      8'h00
`define ATN_REG_CTRL      8'h04
`define ATN_REG_STATUS    8'h08
`define ATN_REG_DIV       8'h0C
`define ATN_REG_PRESET    8'h10
`define ATN_CTRL_GO       0
`define ATN_STAT_BUSY     0
`define ATN_STAT_DONE     1
`define ATN_DIV_RST       8'h07
`define ATN_PRESET_RST    5'h00
`define ATN_RESP_OKAY     2'h0
`define ATN_RESP_SLVERR   2'h2
`endif

// *** pkg/atn_pkg.sv ***
package atn_pkg;
	// Device latch sequencing
	typedef enum logic [1:0] {
		ATN_DST_BOOT = 2'b00,
		ATN_DST_HOLD = 2'b01,
		ATN_DST_OPEN = 2'b10
	} atn_dev_state_t;
	// Controller link sequencing
	typedef enum logic [2:0] {
		ATN_CST_IDLE = 3'b000,
		ATN_CST_LOW  = 3'b001,
		ATN_CST_HIGH = 3'b010,
		ATN_CST_GAP  = 3'b011,
		ATN_CST_STRB = 3'b100
	} atn_ctl_state_t;
endpackage

// *** pkg/atn_link_if.sv ***
`timescale 1ns/1ps
// Three-wire serial link plus the parallel preset pins
interface atn_link_if;
	logic       sclk;        // Serial clock, made by the controller
	logic       sdata;       // Serial data, MSB first
	logic       hold_strobe; // Latch strobe, high = transparent
	logic [4:0] preset;      // Parallel power-up control levels
	modport dev (
		input sclk,
		input sdata,
		input hold_strobe,
		input preset
	);
	modport ctl (
		output sclk,
		output sdata,
		output hold_strobe,
		output preset
	);
endinterface

// *** design/atn_dev.sv ***
`timescale 1ns/1ps
`include "atn_params.svh"
// Attenuator control front end: shift register on the link clock,
// latch and settle tracking on the local clock.
module atn_dev (
	atn_link_if.dev   lnk,
	input  wire logic sys_clk,
	input  wire logic rst,
	output logic      step_8db_ctl,
	output logic      step_4db_ctl,
	output logic      step_2db_ctl,
	output logic      step_1db_ctl,
	output logic      step_half_db_ctl,
	output logic [4:0] atten_half_db,
	output logic      atten_settled
);

	// ****************************************
	// Link clock domain
	// ****************************************

	logic [4:0] shift;      // Serial-in, parallel-out register
	logic [4:0] next_shift; // Shift register next value

	// Next shift value, one place toward the MSB
	always_comb begin
		next_shift = {shift[3:0], lnk.sdata};
	end

	// Register on the link's rising edge
	// The link clock stops between frames, so nothing else lives here
	always_ff @(posedge lnk.sclk or posedge rst) begin
		if (rst) begin
			shift <= 5'h0_0;
		end else begin
			shift <= next_shift;
		end
	end

	// ****************************************
	// Synchronisers into sys_clk
	// ****************************************

	logic       stb_s1;  // Strobe, first stage
	logic       stb_s2;  // Strobe, second stage
	logic       stb_s3;  // Strobe, delayed for edge detect
	logic [4:0] word_s1; // Shift word, first stage
	logic [4:0] word_s2; // Shift word, second stage
	logic [4:0] word_s3; // Shift word, stability check
	logic [4:0] pre_s1;  // Preset pins, first stage
	logic [4:0] pre_s2;  // Preset pins, second stage

	// Two flops per line; word copied only when stable for two samples,
	// which keeps a bit skewed mid-crossing off the outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stb_s1  <= 1'b0;
			stb_s2  <= 1'b0;
			stb_s3  <= 1'b0;
			word_s1 <= 5'h0_0;
			word_s2 <= 5'h0_0;
			word_s3 <= 5'h0_0;
			pre_s1  <= 5'h0_0;
			pre_s2  <= 5'h0_0;
		end else begin
			stb_s1  <= lnk.hold_strobe;
			stb_s2  <= stb_s1;
			stb_s3  <= stb_s2;
			word_s1 <= shift;
			word_s2 <= word_s1;
			word_s3 <= word_s2;
			pre_s1  <= lnk.preset;
			pre_s2  <= pre_s1;
		end
	end

	// ****************************************
	// Latch sequencing
	// ****************************************

	atn_pkg::atn_dev_state_t state;      // Latch state
	atn_pkg::atn_dev_state_t next_state; // Latch state next
	logic [1:0]              boot_cnt;   // Waits for preset syncs
	logic [1:0]              next_boot_cnt;
	logic [4:0]              latch;      // Applied control word
	logic [4:0]              next_latch;

	// Next latch contents
	always_comb begin
		next_state    = state;
		next_boot_cnt = boot_cnt;
		next_latch    = latch;
		case (state)
			// Power-up: fill the syncs, then adopt the preset pins
			atn_pkg::ATN_DST_BOOT: begin
				next_boot_cnt = boot_cnt + 2'd1;
				if (boot_cnt == 2'(`ATN_BOOT_CYC - 1)) begin
					next_latch = pre_s2;
					next_state = atn_pkg::ATN_DST_HOLD;
				end
			end
			// Frozen until a fresh strobe rise; a strobe pulled
			// high at power-up does not clobber the preset
			atn_pkg::ATN_DST_HOLD: begin
				if (stb_s2 && !stb_s3) begin
					next_state = atn_pkg::ATN_DST_OPEN;
				end
			end
			// Transparent while the strobe stays high
			atn_pkg::ATN_DST_OPEN: begin
				if (!stb_s2) begin
					next_state = atn_pkg::ATN_DST_HOLD;
				end else if (word_s2 == word_s3) begin
					next_latch = word_s2;
				end
			end
			// Unused code falls back to frozen
			default: begin
				next_state = atn_pkg::ATN_DST_HOLD;
			end
		endcase
	end

	// Register latch state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state    <= atn_pkg::ATN_DST_BOOT;
			boot_cnt <= 2'd0;
			latch    <= 5'h0_0;
		end else begin
			state    <= next_state;
			boot_cnt <= next_boot_cnt;
			latch    <= next_latch;
		end
	end

	// ****************************************
	// Settle tracking
	// ****************************************

	logic [6:0] settle_cnt;      // Cycles left until settled
	logic [6:0] next_settle_cnt;
	logic       next_settled;

	// Restart the settle window on every applied change
	always_comb begin
		next_settle_cnt = settle_cnt;
		if (next_latch != latch) begin
			next_settle_cnt = 7'(`ATN_SETTLE_CYC);
		end else if (settle_cnt != 7'd0) begin
			next_settle_cnt = settle_cnt - 7'd1;
		end
		next_settled = (next_settle_cnt == 7'd0);
	end

	// Register settle tracking; unsettled through power-up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			settle_cnt    <= 7'd0;
			atten_settled <= 1'b0;
		end else begin
			settle_cnt    <= next_settle_cnt;
			atten_settled <= next_settled && (state != atn_pkg::ATN_DST_BOOT);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// MSB is the 8 dB step
	assign step_8db_ctl     = latch[`ATN_BIT_8DB];
	assign step_4db_ctl     = latch[`ATN_BIT_4DB];
	assign step_2db_ctl     = latch[`ATN_BIT_2DB];
	assign step_1db_ctl     = latch[`ATN_BIT_1DB];
	assign step_half_db_ctl = latch[`ATN_BIT_HALF_DB];
	assign atten_half_db    = latch;

endmodule

// *** design/atn_ctl.sv ***
`timescale 1ns/1ps
`include "atn_params.svh"
// Link controller: AXI4-Lite registers, divided serial clock, strobe.
module atn_ctl (
	atn_link_if.ctl   lnk,
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************
	// Register file and bus slave
	// ****************************************

	logic [4:0] word_reg, next_word;     // Word to send
	logic [7:0] div_reg, next_div;       // Half period in cycles
	logic [4:0] preset_reg, next_preset; // Parallel preset pins
	logic       aw_held, next_aw_held;   // Write address taken
	logic       w_held, next_w_held;     // Write data taken
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic       next_awready, next_wready, next_bvalid, next_arready;
	logic       next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic       go_req;                  // One-cycle start request
	logic       busy, done;

	// Bus next values; write occurs once address and data are both held
	always_comb begin
		next_word = word_reg;
		next_div = div_reg;
		next_preset = preset_reg;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		go_req = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (aw_held && w_held) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `ATN_RESP_OKAY;
			if (aw_addr == `ATN_REG_WORD) begin
				if (w_strb[0]) next_word = w_data[4:0];
			end else if (aw_addr == `ATN_REG_CTRL) begin
				go_req = w_strb[0] && w_data[`ATN_CTRL_GO];
			end else if (aw_addr == `ATN_REG_STATUS) begin
				// Read-only status: write accepted, no effect
			end else if (aw_addr == `ATN_REG_DIV) begin
				if (w_strb[0]) next_div = w_data[7:0];
			end else if (aw_addr == `ATN_REG_PRESET) begin
				if (w_strb[0]) next_preset = w_data[4:0];
			end else begin
				next_bresp = `ATN_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `ATN_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr == `ATN_REG_WORD) begin
				next_rdata[4:0] = word_reg;
			end else if (s_axi_araddr == `ATN_REG_CTRL) begin
				next_rdata = 32'h0000_0000;
			end else if (s_axi_araddr == `ATN_REG_STATUS) begin
				next_rdata[`ATN_STAT_BUSY] = busy;
				next_rdata[`ATN_STAT_DONE] = done;
			end else if (s_axi_araddr == `ATN_REG_DIV) begin
				next_rdata[7:0] = div_reg;
			end else if (s_axi_araddr == `ATN_REG_PRESET) begin
				next_rdata[4:0] = preset_reg;
			end else begin
				next_rresp = `ATN_RESP_SLVERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	// Register bus state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			word_reg <= 5'h0_0;
			div_reg <= `ATN_DIV_RST;
			preset_reg <= `ATN_PRESET_RST;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			word_reg <= next_word;
			div_reg <= next_div;
			preset_reg <= next_preset;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end

	// ****************************************
	// Link sequencer
	// ****************************************

	atn_pkg::atn_ctl_state_t st, next_st;
	logic [7:0] cnt, next_cnt;       // Phase cycle counter
	logic [2:0] bitn, next_bitn;     // Bits clocked so far
	logic [4:0] shreg, next_shreg;   // Outgoing bits, MSB first
	logic       next_sclk, next_sdata, next_strobe, next_busy, next_done;
	logic [7:0] half;                // Half period, clamped to the minimum

	// A too-small divider would break the 10 MHz limit, so clamp it
	// clock rate and phases
	assign half = (div_reg < 8'(`ATN_HALF_MIN_CYC)) ? 8'(`ATN_HALF_MIN_CYC) : div_reg;

	// Sequencer next values
	always_comb begin
		next_st = st;
		next_cnt = cnt + 8'd1;
		next_bitn = bitn;
		next_shreg = shreg;
		next_sclk = lnk.sclk;
		next_sdata = lnk.sdata;
		next_strobe = lnk.hold_strobe;
		next_busy = busy;
		next_done = done;
		case (st)
			// Go while busy is ignored
			atn_pkg::ATN_CST_IDLE: begin
				next_cnt = 8'd0;
				if (go_req) begin
					next_st = atn_pkg::ATN_CST_LOW;
					next_shreg = word_reg;
					next_bitn = 3'd0;
					next_busy = 1'b1;
					next_done = 1'b0;
				end
			end
			atn_pkg::ATN_CST_LOW: begin
				if (cnt == 8'(`ATN_BIT_HOLD_CYC)) begin
					next_sdata = shreg[4];
					next_shreg = {shreg[3:0], 1'b0};
				end
				if (cnt == half - 8'd1) begin
					next_sclk = 1'b1;
					next_cnt = 8'd0;
					next_st = atn_pkg::ATN_CST_HIGH;
				end
			end
			atn_pkg::ATN_CST_HIGH: begin
				if (cnt == half - 8'd1) begin
					next_sclk = 1'b0;
					next_cnt = 8'd0;
					next_bitn = bitn + 3'd1;
					next_st = (bitn == 3'd4) ? atn_pkg::ATN_CST_GAP : atn_pkg::ATN_CST_LOW;
				end
			end
			atn_pkg::ATN_CST_GAP: begin
				if (cnt == 8'(`ATN_STB_SETUP_CYC - 1)) begin
					next_strobe = 1'b1;
					next_cnt = 8'd0;
					next_st = atn_pkg::ATN_CST_STRB;
				end
			end
			atn_pkg::ATN_CST_STRB: begin
				if (cnt == 8'(`ATN_STB_WIDTH_CYC - 1)) begin
					next_strobe = 1'b0;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_st = atn_pkg::ATN_CST_IDLE;
				end
			end
			default: begin
				next_st = atn_pkg::ATN_CST_IDLE;
			end
		endcase
	end

	// Register sequencer and pins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st <= atn_pkg::ATN_CST_IDLE;
			cnt <= 8'd0;
			bitn <= 3'd0;
			shreg <= 5'h0_0;
			busy <= 1'b0;
			done <= 1'b0;
			lnk.sclk <= 1'b0;
			lnk.sdata <= 1'b0;
			lnk.hold_strobe <= 1'b0;
			lnk.preset <= `ATN_PRESET_RST;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			bitn <= next_bitn;
			shreg <= next_shreg;
			busy <= next_busy;
			done <= next_done;
			lnk.sclk <= next_sclk;
			lnk.sdata <= next_sdata;
			lnk.hold_strobe <= next_strobe;
			lnk.preset <= preset_reg;
		end
	end

endmodule

// *** tb/atn_link_properties.sv ***
`timescale 1ns/1ps
// ****************************************
// Link and latch checker
// ****************************************
module atn_properties (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       sclk,
	input wire logic       sdata,
	input wire logic       hold_strobe,
	input wire logic [4:0] preset,
	input wire logic       step_8db_ctl,
	input wire logic       step_4db_ctl,
	input wire logic       step_2db_ctl,
	input wire logic       step_1db_ctl,
	input wire logic       step_half_db_ctl,
	input wire logic [4:0] atten_half_db,
	input wire logic       atten_settled
);
	logic       sclk_q;        // Link clock one sample ago
	logic [4:0] shadow;        // Word rebuilt from the wire
	logic [2:0] rise_cnt;      // Link rises since the last strobe
	logic [3:0] low_cnt;       // Cycles with strobe low, saturating
	logic [4:0] next_shadow;
	logic [2:0] next_rise_cnt;
	logic [3:0] next_low_cnt;

	// Next values of the wire shadow and counters
	always_comb begin
		next_shadow   = shadow;
		next_rise_cnt = rise_cnt;
		next_low_cnt  = low_cnt;
		// Link rise shifts one bit in
		if (sclk && !sclk_q) begin
			next_shadow   = {shadow[3:0], sdata};
			next_rise_cnt = rise_cnt + 3'h1;
		end
		// Strobe restarts both counts
		if (hold_strobe) begin
			next_rise_cnt = 3'h0;
			next_low_cnt  = 4'h0;
		end else if (low_cnt != 4'hf) begin
			next_low_cnt = low_cnt + 4'h1;
		end
	end

	// Register helper state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclk_q   <= 1'b0;
			shadow   <= 5'h00;
			rise_cnt <= 3'h0;
			low_cnt  <= 4'h0;
		end else begin
			sclk_q   <= sclk;
			shadow   <= next_shadow;
			rise_cnt <= next_rise_cnt;
			low_cnt  <= next_low_cnt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_strobe_pulse;
		hold_strobe [*4];
	endsequence
	sequence s_unsettled;
		(!atten_settled) [*8];
	endsequence

	a_bits_match_word: assert property (
		$rose(hold_strobe) |-> ##[1:8] ({step_8db_ctl, step_4db_ctl, step_2db_ctl,
			step_1db_ctl, step_half_db_ctl} == shadow))
		else $error("control bits differ from shifted word");
	a_latch_follows: assert property (
		$rose(hold_strobe) |-> ##[1:8] (atten_half_db == shadow))
		else $error("open latch did not pass the shifted word");
	a_latch_frozen: assert property (
		low_cnt >= 4'hc |-> $stable(atten_half_db))
		else $error("setting moved while strobe low");
	a_power_preset: assert property (
		$fell(rst) |-> ##[3:6] (atten_half_db == preset))
		else $error("power-up setting not taken from preset");
	a_settle_drop: assert property (
		$changed(atten_half_db) && $past(atten_settled) |=> s_unsettled)
		else $error("settled flag stayed high after a change");
	a_settle_bound: assert property (
		$changed(atten_half_db) |-> ##[1:100] atten_settled)
		else $error("settled flag late");
	a_five_rises: assert property (
		$rose(hold_strobe) |-> rise_cnt == 3'h5)
		else $error("strobe not after five link rises");
	a_no_shift_open: assert property (
		$rose(sclk) |-> !hold_strobe)
		else $error("shift while latch open");
	a_clk_high_min: assert property (
		$rose(sclk) |-> sclk [*4])
		else $error("link clock high phase short");
	a_clk_low_min: assert property (
		$fell(sclk) |-> (!sclk) [*4])
		else $error("link clock low phase short");
	a_strobe_setup: assert property (
		$rose(hold_strobe) |-> !$past(sclk, 1) && !$past(sclk, 2))
		else $error("strobe too soon after last fall");
	a_strobe_width: assert property (
		$rose(hold_strobe) |-> s_strobe_pulse)
		else $error("strobe pulse short");
	a_data_setup: assert property (
		$rose(sclk) |-> $stable(sdata) && sdata == $past(sdata, 2))
		else $error("data moved before link rise");
	a_data_hold: assert property (
		$fell(sclk) |-> $stable(sdata) ##1 $stable(sdata))
		else $error("data moved right after link fall");
endmodule

// *** tb/attenuator_serial_control_test.sv ***
`timescale 1ns/1ps
`include "atn_params.svh"
module attenuator_serial_control_test;
	// ****************************************
	// Signals
	// ****************************************
	logic        sys_clk, rst, ctl_rst;                       // Clock, end resets
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        step_8db_ctl, step_4db_ctl, step_2db_ctl, step_1db_ctl, step_half_db_ctl;
	logic [4:0]  atten_half_db, prev, cap;                    // cap: word seen on the wire
	logic        atten_settled;
	logic [7:0]  hi_cnt, hi_len;                              // Link high phase length
	int          num_errors, num_checks, cycles, n;
	logic [4:0]  words [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f, 5'h00, 5'h15};
	logic [7:0]  divs [8]  = '{8'h07, 8'h03, 8'h0a, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07};
	logic [7:0]  reg_a [5] = '{`ATN_REG_WORD, `ATN_REG_CTRL, `ATN_REG_STATUS, `ATN_REG_DIV,
		`ATN_REG_PRESET};

	atn_link_if lnk ();
	atn_ctl u_atn_ctl (.lnk(lnk), .sys_clk(sys_clk), .rst(ctl_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	atn_dev u_atn_dev (.lnk(lnk), .sys_clk(sys_clk), .rst(rst), .step_8db_ctl(step_8db_ctl),
		.step_4db_ctl(step_4db_ctl), .step_2db_ctl(step_2db_ctl), .step_1db_ctl(step_1db_ctl),
		.step_half_db_ctl(step_half_db_ctl), .atten_half_db(atten_half_db),
		.atten_settled(atten_settled));
	atn_properties u_atn_properties (.sys_clk(sys_clk), .rst(rst), .sclk(lnk.sclk),
		.sdata(lnk.sdata), .hold_strobe(lnk.hold_strobe), .preset(lnk.preset),
		.step_8db_ctl(step_8db_ctl), .step_4db_ctl(step_4db_ctl), .step_2db_ctl(step_2db_ctl),
		.step_1db_ctl(step_1db_ctl), .step_half_db_ctl(step_half_db_ctl),
		.atten_half_db(atten_half_db), .atten_settled(atten_settled));

	// Clock source
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Wire-side observers: a word shifted in MSB first, and the last high phase
	always @(posedge lnk.sclk) cap <= {cap[3:0], lnk.sdata};
	always @(posedge sys_clk) begin
		if (lnk.sclk === 1'b1) begin
			hi_cnt <= hi_cnt + 8'h01;
		end else if (hi_cnt != 8'h00) begin
			hi_len <= hi_cnt;
			hi_cnt <= 8'h00;
		end
	end

	// Hang guard: whole run needs under two thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			test_done();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, ctl_rst} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		{cap, hi_cnt, hi_len, num_errors, num_checks, cycles} = '0;
		repeat (4) @(posedge sys_clk);
		rst     <= 1'b0;
		ctl_rst <= 1'b0;
		// Register reset values, unmapped place
		for (int i = 0; i < 5; i++) begin
			axi_rd(reg_a[i], rd, resp);
			chk(rd, (i == 3) ? {24'h00_0000, `ATN_DIV_RST} : 32'h0000_0000, "reset value");
		end
		axi_rd(8'h20, rd, resp);
		chk(32'(resp), 32'(`ATN_RESP_SLVERR), "unmapped read");
		axi_wr(8'h20, 32'h0000_001f, resp);
		chk(32'(resp), 32'(`ATN_RESP_SLVERR), "unmapped write");
		axi_wr(`ATN_REG_WORD, 32'h1234_5678, resp);
		axi_rd(`ATN_REG_WORD, rd, resp);
		chk(rd, 32'h0000_0018, "word keeps low bits");
		$display("test registers done");
		// Preset levels picked up when the attenuator end comes out of reset
		chk(32'(atten_half_db), 32'h0000_0000, "first power-up setting");
		axi_wr(`ATN_REG_PRESET, 32'h0000_0013, resp);
		@(posedge sys_clk) rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(32'(atten_half_db), 32'h0000_0000, "cleared in reset");
		rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(32'(atten_half_db), 32'h0000_0013, "preset power-up setting");
		while (atten_settled !== 1'b1) @(posedge sys_clk);
		$display("test preset done");
		// Words through the link, with phase lengths set by the divider
		for (int i = 0; i < 8; i++) begin
			prev = atten_half_db;
			axi_wr(`ATN_REG_DIV, {24'h00_0000, divs[i]}, resp);
			axi_wr(`ATN_REG_WORD, {27'h000_0000, words[i]}, resp);
			axi_wr(`ATN_REG_CTRL, 32'h0000_0001, resp);
			axi_rd(`ATN_REG_STATUS, rd, resp);
			chk(rd, 32'h0000_0001, "busy while sending");
			chk(32'(atten_half_db), 32'(prev), "setting frozen while shifting");
			do axi_rd(`ATN_REG_STATUS, rd, resp); while (rd[1] !== 1'b1);
			chk(rd, 32'h0000_0002, "done and idle");
			repeat (8) @(posedge sys_clk);
			if (words[i] != prev) chk(32'(atten_settled), 32'h0000_0000, "unsettled");
			n = 0;
			while (atten_settled !== 1'b1) begin
				@(posedge sys_clk);
				n++;
			end
			chk(32'(n <= 88), 32'h0000_0001, "settle time");
			chk(32'(atten_half_db), 32'(words[i]), "applied word");
			chk(32'({step_8db_ctl, step_4db_ctl, step_2db_ctl, step_1db_ctl,
				step_half_db_ctl}), 32'(words[i]), "weighted bits");
			chk(32'(cap), 32'(words[i]), "bit order on the wire");
			chk(32'(hi_len), (divs[i] < 8'h07) ? 32'h0000_0007 : 32'(divs[i]), "phase");
		end
		$display("test words done");
		test_done();
	end
endmodule
